// ==== shared/csv_defines.svh ====
// What this block does
// - card insertion into an unpowered socket starts an interrogation before power
// - both card detects grounded means 16-bit card; voltage from sense pattern
// - detect strapped to sense means 32-bit card; two strap combinations are reserved
// - socket power switch is driven over clock, data and latch terminals
// - after reset the switch clock pin is an input timing the interface
// - system control bit 27 set: switch clock made from core clock, driven out
// - video pass-through enable bit 6 floats card address lines 25 to 4
// - card address lines 3 to 0 keep driving during video pass-through
// - active-low select per socket shows which socket is the video source
// - both sockets enabled: socket 0 wins unless priority bit 5 is set
// - video active output high while either socket has pass-through enabled
// - 16-bit card dma fetches 32 bits per host read
// - spare half word feeds the next card transfer before another fetch
// - the 32-bit prefetch is always on, no enable bit
// - internal ring oscillator of about 16 kHz times interrogation without other clocks
// - ring oscillator off after reset, runs while system control bit 27 is 1
`ifndef CSV_DEFINES_SVH
`define CSV_DEFINES_SVH

// register byte offsets
`define CSV_REG_SYSCTL 8'h80
`define CSV_REG_CC0 8'h04
`define CSV_REG_CC1 8'h08
`define CSV_REG_STATUS 8'h0C
`define CSV_REG_PSW 8'h10

// field positions
`define CSV_SYSCTL_SWCLK_BIT 27
`define CSV_CC_VIDEN_BIT 6
`define CSV_CC_PRI_BIT 5

// reset values
`define CSV_SYSCTL_RST 32'h0000_0000
`define CSV_CC_RST 8'h00

// sizes
`define CSV_PSW_BITS 8

// timing
`define CSV_CLK_HZ 10000000
`define CSV_CLK_NS 100
`define CSV_OSC_HZ 16000
`define CSV_OSC_HALF_CYC (`CSV_CLK_HZ / `CSV_OSC_HZ / 2)
`define CSV_SWCLK_HALF_NS 500
`define CSV_SWCLK_HALF_CYC (`CSV_SWCLK_HALF_NS / `CSV_CLK_NS)
`define CSV_SETTLE_NS 1000
`define CSV_SETTLE_CYC ((`CSV_SETTLE_NS + `CSV_CLK_NS - 1) / `CSV_CLK_NS)

`endif

// ==== shared/csv_pkg.sv ====
`default_nettype none
package csv_pkg;
    typedef enum logic [1:0] {CSV_CARD_NONE, CSV_CARD_16BIT, CSV_CARD_32BIT, CSV_CARD_RESERVED} csv_card_t;
    typedef enum logic [2:0] {DET_IDLE, DET_OPEN, DET_DRV_A, DET_DRV_B, DET_DONE} csv_det_st_t;
    typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_LATCH} csv_ser_st_t;

    typedef struct packed {
        csv_ser_st_t st;
        logic [7:0] sr;
        logic [3:0] cnt;
        logic data;
        logic latch;
    } csv_ser_t;

    typedef struct packed {
        logic req;
        logic hv;
        logic [15:0] hd;
        logic [15:0] hi;
        logic hi_v;
    } csv_pf_t;

    typedef struct packed {
        logic ack;
        logic wreq;
        logic [31:0] rdata;
        logic [31:0] sysctl;
        logic [7:0] cc0;
        logic [7:0] cc1;
        logic [7:0] psw_word;
        logic psw_start;
        csv_det_st_t det_st;
        logic [3:0] settle;
        logic [1:0] open_cd;
        logic [1:0] open_vs;
        logic [3:0] strap;
        csv_card_t card;
        logic [1:0] vs_oe;
        logic sel0_n;
        logic sel1_n;
        logic vid_act;
        logic [25:0] addr;
        logic [25:0] oe0;
        logic [25:0] oe1;
        logic [9:0] osc_cnt;
        logic osc_clk;
        logic osc_tick;
        logic [3:0] swdiv;
        logic swclk_o;
        logic swclk_oe;
        logic swclk_prev;
        logic sw_tick;
    } csv_top_t;
endpackage
`default_nettype wire

// ==== logic/csv_switch_serial.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "csv_defines.svh"
module csv_switch_serial (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // request
    input wire logic start_in,
    input wire logic [`CSV_PSW_BITS-1:0] word_in,
    input wire logic shift_tick_in,
    // switch pins and state
    output logic data_out,
    output logic latch_out,
    output logic busy_out
);
    csv_pkg::csv_ser_t s;
    csv_pkg::csv_ser_t next_s;

    // data changes on the falling switch clock so the switch samples it stable on the rise
    always_comb begin
        next_s = s;
        unique case (s.st)
            csv_pkg::SER_IDLE: begin
                if (start_in) begin
                    next_s.sr = word_in;
                    next_s.cnt = 4'(`CSV_PSW_BITS);
                    next_s.st = csv_pkg::SER_SHIFT;
                end
            end
            csv_pkg::SER_SHIFT: begin
                if (shift_tick_in) begin
                    if (s.cnt != 4'h0) begin
                        next_s.data = s.sr[`CSV_PSW_BITS-1];
                        next_s.sr = {s.sr[`CSV_PSW_BITS-2:0], 1'b0};
                        next_s.cnt = s.cnt - 4'h1;
                    end else begin
                        next_s.data = 1'b0;
                        next_s.latch = 1'b1;
                        next_s.st = csv_pkg::SER_LATCH;
                    end
                end
            end
            csv_pkg::SER_LATCH: begin
                // latch stays high one whole switch clock period
                if (shift_tick_in) begin
                    next_s.latch = 1'b0;
                    next_s.st = csv_pkg::SER_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign data_out = s.data;
    assign latch_out = s.latch;
    assign busy_out = (s.st != csv_pkg::SER_IDLE);
endmodule
`default_nettype wire

// ==== logic/csv_prefetch.sv ====
`timescale 1ns/1ps
`default_nettype none
module csv_prefetch (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // host memory side
    input wire logic dma_active_in,
    input wire logic fetch_valid_in,
    input wire logic [31:0] fetch_data_in,
    output logic fetch_req_out,
    // card side, one half word at a time
    input wire logic half_ready_in,
    output logic half_valid_out,
    output logic [15:0] half_data_out
);
    csv_pkg::csv_pf_t s;
    csv_pkg::csv_pf_t next_s;

    // always active, no enable: a new fetch only once both halves are gone
    always_comb begin
        next_s = s;
        if (s.hv && half_ready_in) begin
            next_s.hv = 1'b0;
        end
        if (!next_s.hv && s.hi_v) begin
            next_s.hd = s.hi;
            next_s.hv = 1'b1;
            next_s.hi_v = 1'b0;
        end
        if (s.req && fetch_valid_in) begin
            next_s.hd = fetch_data_in[15:0];
            next_s.hi = fetch_data_in[31:16];
            next_s.hv = 1'b1;
            next_s.hi_v = 1'b1;
            next_s.req = 1'b0;
        end else if (dma_active_in && !s.req && !next_s.hv && !next_s.hi_v) begin
            next_s.req = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign fetch_req_out = s.req;
    assign half_valid_out = s.hv;
    assign half_data_out = s.hd;
endmodule
`default_nettype wire

// ==== logic/csv_socket_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "csv_defines.svh"
module csv_socket_ctrl (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    // avalon-mm slave
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // card detect and voltage sense
    input wire logic socket_power_on_in,
    input wire logic card_detect_a_in,
    input wire logic card_detect_b_in,
    input wire logic voltage_sense_a_in,
    input wire logic voltage_sense_b_in,
    output logic voltage_sense_a_out,
    output logic voltage_sense_a_oe_out,
    output logic voltage_sense_b_out,
    output logic voltage_sense_b_oe_out,
    // power switch serial interface
    input wire logic switch_clock_in,
    output logic switch_clock_out,
    output logic switch_clock_oe_out,
    output logic switch_data_out,
    output logic switch_latch_out,
    // card address lines and video pass-through
    input wire logic [25:0] card_addr_in,
    input wire logic card_addr_drive_in,
    output logic [25:0] card0_addr_out,
    output logic [25:0] card0_addr_oe_out,
    output logic [25:0] card1_addr_out,
    output logic [25:0] card1_addr_oe_out,
    output logic video_socket0_sel_n_out,
    output logic video_socket1_sel_n_out,
    output logic video_any_active_out,
    // dma prefetch
    input wire logic dma_active_in,
    input wire logic fetch_valid_in,
    input wire logic [31:0] fetch_data_in,
    output logic fetch_req_out,
    input wire logic half_ready_in,
    output logic half_valid_out,
    output logic [15:0] half_data_out,
    // internal ring oscillator
    output logic ring_osc_out
);
    csv_pkg::csv_top_t s;
    csv_pkg::csv_top_t next_s;
    logic psw_busy;
    logic sw_on;
    logic en0;
    logic en1;
    logic pri;
    logic step;

    // one strap at most is legal; two combos are reserved
    function automatic csv_pkg::csv_card_t csv_classify(input logic [3:0] strap, input logic [1:0] cd,
                                                        input logic [1:0] vs);
        if (strap == 4'h0) begin
            return (cd == 2'b00) ? csv_pkg::CSV_CARD_16BIT : csv_pkg::CSV_CARD_NONE;
        end else if ($countones(strap) != 1) begin
            return csv_pkg::CSV_CARD_RESERVED;
        end else if ((strap[0] && !vs[1]) || (strap[1] && !vs[0])) begin
            return csv_pkg::CSV_CARD_RESERVED;
        end
        return csv_pkg::CSV_CARD_32BIT;
    endfunction

    assign sw_on = s.sysctl[`CSV_SYSCTL_SWCLK_BIT];
    assign en0 = s.cc0[`CSV_CC_VIDEN_BIT];
    assign en1 = s.cc1[`CSV_CC_VIDEN_BIT];
    assign pri = s.cc0[`CSV_CC_PRI_BIT];
    // settle time runs on the ring oscillator when it runs, else on the core clock
    assign step = sw_on ? s.osc_tick : 1'b1;

    always_comb begin
        next_s = s;
        next_s.psw_start = 1'b0;
        // bus slave: one wait cycle, answer registered
        next_s.ack = (avs_read_in || avs_write_in) && !s.ack;
        next_s.wreq = !next_s.ack;
        if (avs_read_in && !s.ack) begin
            unique case (avs_address_in)
                `CSV_REG_SYSCTL: next_s.rdata = s.sysctl;
                `CSV_REG_CC0: next_s.rdata = {24'h00_0000, s.cc0};
                `CSV_REG_CC1: next_s.rdata = {24'h00_0000, s.cc1};
                `CSV_REG_STATUS: next_s.rdata = {21'h00_0000, s.sysctl[`CSV_SYSCTL_SWCLK_BIT], psw_busy,
                                                 (s.det_st != csv_pkg::DET_IDLE), s.strap, s.open_vs, s.card};
                `CSV_REG_PSW: next_s.rdata = {24'h00_0000, s.psw_word};
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
        if (avs_write_in && s.ack) begin
            unique case (avs_address_in)
                `CSV_REG_SYSCTL: next_s.sysctl = avs_writedata_in;
                `CSV_REG_CC0: next_s.cc0 = avs_writedata_in[7:0];
                `CSV_REG_CC1: next_s.cc1 = avs_writedata_in[7:0];
                `CSV_REG_PSW: begin
                    next_s.psw_word = avs_writedata_in[7:0];
                    next_s.psw_start = 1'b1;
                end
                default: next_s.sysctl = s.sysctl;
            endcase
        end

        // ring oscillator, stopped and parked low while disabled
        next_s.osc_tick = 1'b0;
        if (sw_on) begin
            if (s.osc_cnt == 10'(`CSV_OSC_HALF_CYC - 1)) begin
                next_s.osc_cnt = 10'h000;
                next_s.osc_clk = !s.osc_clk;
                next_s.osc_tick = !s.osc_clk;
            end else begin
                next_s.osc_cnt = s.osc_cnt + 10'h001;
            end
        end else begin
            next_s.osc_cnt = 10'h000;
            next_s.osc_clk = 1'b0;
        end

        // switch clock: generated and driven, or taken from the pin
        next_s.swclk_prev = switch_clock_in;
        next_s.sw_tick = 1'b0;
        if (sw_on) begin
            next_s.swclk_oe = 1'b1;
            if (s.swdiv == 4'h0) begin
                next_s.swdiv = 4'(`CSV_SWCLK_HALF_CYC - 1);
                next_s.swclk_o = !s.swclk_o;
                next_s.sw_tick = s.swclk_o;
            end else begin
                next_s.swdiv = s.swdiv - 4'h1;
            end
        end else begin
            next_s.swclk_oe = 1'b0;
            next_s.swclk_o = 1'b0;
            next_s.swdiv = 4'h0;
            next_s.sw_tick = s.swclk_prev && !switch_clock_in;
        end

        // interrogation: sample released, then pull each sense low in turn
        unique case (s.det_st)
            csv_pkg::DET_IDLE: begin
                next_s.vs_oe = 2'b00;
                if (!socket_power_on_in && s.card == csv_pkg::CSV_CARD_NONE
                    && (!card_detect_a_in || !card_detect_b_in)) begin
                    next_s.det_st = csv_pkg::DET_OPEN;
                    next_s.settle = 4'(`CSV_SETTLE_CYC);
                end else if (card_detect_a_in && card_detect_b_in) begin
                    next_s.card = csv_pkg::CSV_CARD_NONE;
                end
            end
            csv_pkg::DET_OPEN: begin
                if (s.settle != 4'h0) begin
                    next_s.settle = s.settle - {3'h0, step};
                end else begin
                    next_s.open_cd = {card_detect_b_in, card_detect_a_in};
                    next_s.open_vs = {voltage_sense_b_in, voltage_sense_a_in};
                    next_s.vs_oe = 2'b01;
                    next_s.settle = 4'(`CSV_SETTLE_CYC);
                    next_s.det_st = csv_pkg::DET_DRV_A;
                end
            end
            csv_pkg::DET_DRV_A: begin
                if (s.settle != 4'h0) begin
                    next_s.settle = s.settle - {3'h0, step};
                end else begin
                    next_s.strap[0] = s.open_cd[0] && !card_detect_a_in;
                    next_s.strap[2] = s.open_cd[1] && !card_detect_b_in;
                    next_s.vs_oe = 2'b10;
                    next_s.settle = 4'(`CSV_SETTLE_CYC);
                    next_s.det_st = csv_pkg::DET_DRV_B;
                end
            end
            csv_pkg::DET_DRV_B: begin
                if (s.settle != 4'h0) begin
                    next_s.settle = s.settle - {3'h0, step};
                end else begin
                    next_s.strap[1] = s.open_cd[0] && !card_detect_a_in;
                    next_s.strap[3] = s.open_cd[1] && !card_detect_b_in;
                    next_s.vs_oe = 2'b00;
                    next_s.det_st = csv_pkg::DET_DONE;
                end
            end
            csv_pkg::DET_DONE: begin
                next_s.card = csv_classify(s.strap, s.open_cd, s.open_vs);
                next_s.det_st = csv_pkg::DET_IDLE;
            end
            default: next_s.det_st = csv_pkg::DET_IDLE;
        endcase

        // video pass-through selects and address float
        next_s.sel0_n = !(en0 && !(en1 && pri));
        next_s.sel1_n = !(en1 && (!en0 || pri));
        next_s.vid_act = en0 || en1;
        next_s.addr = card_addr_in;
        next_s.oe0 = card_addr_drive_in ? {{22{!en0}}, 4'hF} : 26'h000_0000;
        next_s.oe1 = card_addr_drive_in ? {{22{!en1}}, 4'hF} : 26'h000_0000;
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s <= '0;
            s.wreq <= 1'b1;
            s.sysctl <= `CSV_SYSCTL_RST;
            s.cc0 <= `CSV_CC_RST;
            s.cc1 <= `CSV_CC_RST;
            s.sel0_n <= 1'b1;
            s.sel1_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    csv_switch_serial u_serial (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .start_in(s.psw_start),
        .word_in(s.psw_word),
        .shift_tick_in(s.sw_tick),
        .data_out(switch_data_out),
        .latch_out(switch_latch_out),
        .busy_out(psw_busy)
    );

    csv_prefetch u_prefetch (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .dma_active_in(dma_active_in),
        .fetch_valid_in(fetch_valid_in),
        .fetch_data_in(fetch_data_in),
        .fetch_req_out(fetch_req_out),
        .half_ready_in(half_ready_in),
        .half_valid_out(half_valid_out),
        .half_data_out(half_data_out)
    );

    // outputs straight from state flops, sense drive levels tied low
    assign avs_readdata_out = s.rdata;
    assign avs_waitrequest_out = s.wreq;
    assign voltage_sense_a_out = 1'b0;
    assign voltage_sense_b_out = 1'b0;
    assign voltage_sense_a_oe_out = s.vs_oe[0];
    assign voltage_sense_b_oe_out = s.vs_oe[1];
    assign switch_clock_out = s.swclk_o;
    assign switch_clock_oe_out = s.swclk_oe;
    assign card0_addr_out = s.addr;
    assign card1_addr_out = s.addr;
    assign card0_addr_oe_out = s.oe0;
    assign card1_addr_oe_out = s.oe1;
    assign video_socket0_sel_n_out = s.sel0_n;
    assign video_socket1_sel_n_out = s.sel1_n;
    assign video_any_active_out = s.vid_act;
    assign ring_osc_out = s.osc_clk;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    a_video_sel_excl: assert property (video_socket0_sel_n_out || video_socket1_sel_n_out)
        else $error("both video selects low");
    a_video_prio_def: assert property (en0 && en1 && !pri |=>
                                       !video_socket0_sel_n_out && video_socket1_sel_n_out)
        else $error("socket 0 not chosen by default");
    a_video_prio_one: assert property (en0 && en1 && pri |=>
                                       video_socket0_sel_n_out && !video_socket1_sel_n_out)
        else $error("priority bit ignored");
    a_video_active: assert property ((en0 || en1) |=> video_any_active_out)
        else $error("video active low while enabled");
    a_addr_hi_float: assert property (en0 |=> card0_addr_oe_out[25:4] == 22'h00_0000)
        else $error("upper address driven in video mode");
    a_addr_lo_drive: assert property (en1 && card_addr_drive_in |=> card1_addr_oe_out[3:0] == 4'hF)
        else $error("low address not driven");
    a_swclk_pin_dir: assert property (sw_on ##1 sw_on |=> switch_clock_oe_out)
        else $error("switch clock not driven");
    a_swclk_input: assert property (!sw_on |=> !switch_clock_oe_out)
        else $error("switch clock driven while input");
    a_osc_stopped: assert property (!sw_on ##1 !sw_on |=> !ring_osc_out && $stable(ring_osc_out))
        else $error("ring oscillator runs while off");
    a_probe_unpowered: assert property (s.det_st == csv_pkg::DET_IDLE && next_s.det_st == csv_pkg::DET_OPEN
                                        |-> !socket_power_on_in)
        else $error("interrogation on powered socket");
    a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("bus answer late");

    c_card_16: cover property (s.card == csv_pkg::CSV_CARD_16BIT);
    c_card_32: cover property (s.card == csv_pkg::CSV_CARD_32BIT);
    c_latch: cover property ($rose(switch_latch_out));
    c_both_video: cover property (en0 && en1 && pri);
endmodule
`default_nettype wire

// ==== bench/csv_far_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module csv_far_model (
    // card in the socket
    input wire logic present_in,
    input wire logic [3:0] strap_in,
    input wire logic [1:0] vs_gnd_in,
    input wire logic [1:0] cd_gnd_in,
    input wire logic [1:0] vs_oe_in,
    output logic cd_a_out,
    output logic cd_b_out,
    output logic vs_a_out,
    output logic vs_b_out,
    // power switch
    input wire logic run_in,
    input wire logic sw_clk_in,
    input wire logic data_in,
    input wire logic latch_in,
    output logic clk_out,
    output logic [7:0] word_out,
    output int latches_out
);
    logic [7:0] sr = 8'h00;
    // a strapped detect only reads low while its sense line is pulled low
    assign cd_a_out = !present_in || (|strap_in[1:0] ? !(|(strap_in[1:0] & vs_oe_in)) : !cd_gnd_in[0]);
    assign cd_b_out = !present_in || (|strap_in[3:2] ? !(|(strap_in[3:2] & vs_oe_in)) : !cd_gnd_in[1]);
    // open sense lines rest at the pull-up level
    assign vs_a_out = !(vs_oe_in[0] || (present_in && vs_gnd_in[0]));
    assign vs_b_out = !(vs_oe_in[1] || (present_in && vs_gnd_in[1]));
    // external switch clock stands still outside frames
    initial begin
        clk_out = 1'b0;
        forever begin
            #500;
            if (run_in) clk_out = !clk_out;
        end
    end
    // switch takes data on rising clock, word moves on latch
    always @(posedge sw_clk_in) sr <= {sr[6:0], data_in};
    always @(posedge latch_in) begin
        word_out <= sr;
        latches_out <= latches_out + 1;
    end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, rst_b = 0, rd = 0, wr = 0, run = 0, present = 0, dma = 0, fv = 0, hr = 0, pwr = 0, drv = 1;
    logic [7:0] addr = 8'h00, word, w;
    logic [31:0] wd = 32'h0, fd = 32'h0, rdat, st, rdo, r;
    logic [25:0] ca = 26'h0, a0, e0, a1, e1;
    logic [3:0] strap = 4'h0;
    logic [1:0] vsg = 2'h0, cdg = 2'h0;
    wire logic [1:0] vs_oe;
    logic cda, cdb, vsa, vsb, ext, swo, swoe, sdat, slat, wq, s0, s1, act, fr, hv, osc, po, vo_a, vo_b;
    logic [15:0] hd;
    int lat, n, edges, errors = 0, comparisons = 0;
    localparam logic [7:0] CASES [6] = '{8'h03, 8'h0F, 8'h12, 8'h1A, 8'h26, 8'h22};
    wire logic sw_wire = swoe ? swo : ext;
    initial forever #50 clk = ~clk;
    csv_socket_ctrl i_dut (.core_clk_in(clk), .rst_b_in(rst_b), .avs_address_in(addr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdo), .avs_waitrequest_out(wq),
        .socket_power_on_in(pwr), .card_detect_a_in(cda), .card_detect_b_in(cdb), .voltage_sense_a_in(vsa),
        .voltage_sense_b_in(vsb), .voltage_sense_a_out(vo_a), .voltage_sense_a_oe_out(vs_oe[0]),
        .voltage_sense_b_out(vo_b), .voltage_sense_b_oe_out(vs_oe[1]), .switch_clock_in(sw_wire),
        .switch_clock_out(swo), .switch_clock_oe_out(swoe), .switch_data_out(sdat), .switch_latch_out(slat),
        .card_addr_in(ca), .card_addr_drive_in(drv), .card0_addr_out(a0), .card0_addr_oe_out(e0),
        .card1_addr_out(a1), .card1_addr_oe_out(e1), .video_socket0_sel_n_out(s0), .video_socket1_sel_n_out(s1),
        .video_any_active_out(act), .dma_active_in(dma), .fetch_valid_in(fv), .fetch_data_in(fd),
        .fetch_req_out(fr), .half_ready_in(hr), .half_valid_out(hv), .half_data_out(hd), .ring_osc_out(osc));
    csv_far_model i_far (.present_in(present), .strap_in(strap), .vs_gnd_in(vsg), .cd_gnd_in(cdg),
        .vs_oe_in(vs_oe), .cd_a_out(cda), .cd_b_out(cdb), .vs_a_out(vsa), .vs_b_out(vsb), .run_in(run),
        .sw_clk_in(sw_wire), .data_in(sdat), .latch_in(slat), .clk_out(ext), .word_out(word), .latches_out(lat));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one request held until waitrequest is seen low, then a spare edge
    task bus(input logic wn, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        addr <= a;
        wd <= d;
        wr <= wn;
        rd <= !wn;
        do begin
            @(posedge clk);
            k++;
        end while (wq !== 1'b0 && k < 50);
        rdat = rdo;
        if (wq !== 1'b0) errors++;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    // poll status until a card shows (want=1) or is gone (want=0)
    task poll(input logic want);
        n = 0;
        do begin
            bus(1'b0, 8'h0C, 32'h0);
            st = rdat;
            n++;
        end while ((((st[1:0] == 2'd0) == want) || st[8] !== 1'b0) && n < 200);
        if (n >= 200) errors++;
    endtask
    // reference classification, two single straps with a grounded sense are reserved
    function automatic logic [1:0] exp_card(input logic [3:0] s, input logic [1:0] v, input logic [1:0] c);
        if ($countones(s) > 1 || (s == 4'h1 && v[1]) || (s == 4'h2 && v[0])) return 2'd3;
        if (s != 4'h0) return 2'd2;
        return (c == 2'b11) ? 2'd1 : 2'd0;
    endfunction
    task report_and_stop;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // whole run is about 2k cycles
    initial begin
        #(100 * 30000);
        errors++;
        report_and_stop;
    end
    initial begin
        void'($urandom(79537));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        bus(1'b0, 8'h80, 32'h0);
        chk(rdat, 32'h0);
        bus(1'b0, 8'h44, 32'h0);
        chk(rdat, 32'h0);
        chk({swoe, osc, vo_a, vo_b}, 32'h0);
        for (int i = 0; i < 8; i++) begin
            ca <= 26'($urandom);
            drv <= (i != 6);
            bus(1'b1, 8'h04, {25'h0, i[0], i[2], 5'h0});
            bus(1'b1, 8'h08, {25'h0, i[1], 6'h0});
            @(posedge clk);
            chk({s0, s1}, {!(i[0] && !(i[1] && i[2])), !(i[1] && !(i[0] && !i[2]))});
            chk(32'(act), 32'(i[0] | i[1]));
            chk(32'(e0), 32'({i[0] ? 22'h0 : 22'h3FFFFF, 4'hF}) & {32{drv}});
            chk(32'(e1), 32'({i[1] ? 22'h0 : 22'h3FFFFF, 4'hF}) & {32{drv}});
            chk(32'(a0), 32'(ca));
            chk(32'(a1), 32'(ca));
        end
        // a card in a powered socket is left alone
        pwr <= 1'b1;
        {strap, vsg, cdg} <= 8'h03;
        present <= 1'b1;
        repeat (50) @(posedge clk);
        bus(1'b0, 8'h0C, 32'h0);
        chk(32'(rdat[8:0]), 32'h0);
        present <= 1'b0;
        pwr <= 1'b0;
        @(posedge clk);
        foreach (CASES[k]) begin
            {strap, vsg, cdg} <= CASES[k];
            present <= 1'b1;
            poll(1'b1);
            chk(32'(st[1:0]), 32'(exp_card(strap, vsg, cdg)));
            chk(32'(st[3:2]), 32'(vsg ^ 2'b11));
            present <= 1'b0;
            poll(1'b0);
        end
        repeat (2) begin
            w = 8'($urandom);
            n = lat;
            bus(1'b1, 8'h10, {24'h0, w});
            run <= 1'b1;
            for (int j = 0; j < 400 && lat == n; j++) @(posedge clk);
            repeat (20) @(posedge clk);
            run <= 1'b0;
            chk(32'(word), 32'(w));
        end
        dma <= 1'b1;
        repeat (2) begin
            r = $urandom;
            for (int j = 0; j < 50 && fr !== 1'b1; j++) @(posedge clk);
            fd <= r;
            fv <= 1'b1;
            @(posedge clk);
            fv <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            chk({fr, hv, hd}, {14'h0, 2'b01, r[15:0]});
            @(posedge clk);
            hr <= 1'b1;
            @(posedge clk);
            hr <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            chk({fr, hv, hd}, {14'h0, 2'b01, r[31:16]});
            @(posedge clk);
            hr <= 1'b1;
            @(posedge clk);
            hr <= 1'b0;
        end
        bus(1'b1, 8'h80, 32'h0800_0000);
        n = lat;
        w = 8'($urandom);
        bus(1'b1, 8'h10, {24'h0, w});
        edges = 0;
        po = osc;
        for (int j = 0; j < 1400; j++) begin
            @(posedge clk);
            if (osc !== po) edges++;
            po = osc;
        end
        chk(32'(swoe), 32'h1);
        chk(32'(word), 32'(w));
        chk(32'(lat - n), 32'h1);
        chk(32'(edges >= 4 && edges <= 5), 32'h1);
        report_and_stop;
    end
endmodule
`default_nettype wire
